// file: rtl/hsra_pkg.sv
// Shared constants for the host slave register access link
package hsra_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int GROUP_W = 2;
    localparam int NUM_GROUPS = 4;
    localparam logic [ADDR_W-1:0] OFS_GROUP_BASE = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_DUAL_BASE = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_SVC_REQ = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_TX_SLOT = 12'h200;
    localparam logic [ADDR_W-1:0] OFS_TX_SUB = 12'h280;
    localparam logic [ADDR_W-1:0] OFS_TX_CHAN = 12'h380;
    localparam logic [ADDR_W-1:0] OFS_RX_SLOT = 12'h400;
    localparam logic [ADDR_W-1:0] OFS_RX_SUB = 12'h480;
    localparam logic [ADDR_W-1:0] OFS_RX_CHAN = 12'h580;
    localparam logic [ADDR_W-1:0] OFS_DEVICE_WIDE = 12'h600;
    localparam logic [ADDR_W-1:0] OFS_EVQ_PTR = 12'h604;
    localparam logic [ADDR_W-1:0] OFS_EVQ_LEN = 12'h608;
    localparam logic [ADDR_W-1:0] OFS_GROUP_SET = 12'h60C;
    localparam logic [ADDR_W-1:0] OFS_RANGE_GUARD = 12'h610;
    localparam logic [ADDR_W-1:0] OFS_FRAME_LIM = 12'h614;
    localparam logic [ADDR_W-1:0] OFS_PORT_SET = 12'h618;
    localparam logic [ADDR_W-1:0] OFS_RAM_END = 12'h600;
    localparam logic [ADDR_W-1:0] RAM_SPAN = 12'h080;
    localparam logic [DATA_W-1:0] DEAD_ACCESS_WORD = 32'hDEADACCE;
    localparam logic [DATA_W-1:0] ALL_ONES = 32'hFFFFFFFF;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h00000000;
    localparam logic [DATA_W-1:0] BASE_ALIGN_MASK = 32'hFFFFF800;
    localparam int GROUP_STRUCT_BYTES = 1564;
    localparam int RAM_WORDS = 256;
    localparam int RAM_IDX_W = 8;
    localparam int DMA_LATENCY = 2;
    localparam logic [1:0] DMA_LAT_CNT = 2'h2;
    localparam int SETTLE_CYCLES = 1;
    localparam logic [1:0] SETTLE_CNT = 2'h1;
    localparam logic [DATA_W-1:0] SVC_SOFT_RESET = 32'h00000001;
endpackage

// file: rtl/hsra_if.sv
// Slave access link between the host bridge end and the controller end
`timescale 1ns/100ps
interface hsra_if;
    logic req;
    logic wr;
    logic [hsra_pkg::GROUP_W-1:0] grp;
    logic [hsra_pkg::ADDR_W-1:0] addr;
    logic [hsra_pkg::DATA_W-1:0] wdata;
    logic done;
    logic [hsra_pkg::DATA_W-1:0] rdata;
    modport host (output req, wr, grp, addr, wdata, input done, rdata);
    modport dev (input req, wr, grp, addr, wdata, output done, rdata);
endinterface // hsra_if

// file: rtl/hsra_dev.sv
// Controller end: host interface registers and per-group channel RAM
// Notes on behaviour
// - Host requests service via doorbell register write
// - Channel RAM via DMA path, registers direct
// - All idle: RAM and registers fully accessible
// - RAM access needs group line clocks running
// - Dead clocks: RAM read returns dead word
// - Dead clocks: RAM write discarded
// - Bad address or write-only reads all ones
// - Bad address or read-only bits ignore writes
// - Active channel: host limits access targets
// - Active channel: other registers are forbidden
// - Host writes 2 kB aligned base pointer
// - No request updates base; requests use it
// - Fixed descriptor offsets, device-wide at 0x600
// - Transmit maps at fixed offsets and sizes
// - Receive maps mirror transmit at own offsets
// - Host waits a clock after soft reset
`timescale 1ns/100ps
module hsra_dev (
    input wire logic I_CLOCK, // System clock
    input wire logic I_SRST, // Synchronous reset
    hsra_if.dev LINK, // Slave access link
    input wire logic [hsra_pkg::NUM_GROUPS-1:0] I_LINE_CLK_OK, // Tx and rx line clocks live
    input wire logic I_CHAN_ACTIVE, // Any channel active
    output logic O_SVC_STROBE, // Service request issued
    output logic [hsra_pkg::GROUP_W-1:0] O_SVC_GROUP, // Group of that request
    output logic [hsra_pkg::DATA_W-1:0] O_SVC_CODE, // Request word
    output logic [hsra_pkg::DATA_W-1:0] O_SVC_BASE // Base pointer the request uses
);
    typedef enum logic [1:0] {ST_IDLE, ST_DMA, ST_DONE} hsra_st_t;
    typedef struct packed {
        hsra_st_t st;
        logic [1:0] cnt;
        logic done;
        logic [hsra_pkg::DATA_W-1:0] rdata;
        logic [hsra_pkg::NUM_GROUPS-1:0][hsra_pkg::DATA_W-1:0] base;
        logic [hsra_pkg::NUM_GROUPS-1:0][hsra_pkg::DATA_W-1:0] dual;
        logic [hsra_pkg::NUM_GROUPS-1:0][hsra_pkg::DATA_W-1:0] svc;
        logic [hsra_pkg::NUM_GROUPS-1:0][hsra_pkg::DATA_W-1:0] ists;
        logic [hsra_pkg::NUM_GROUPS-1:0][hsra_pkg::DATA_W-1:0] gset;
        logic [hsra_pkg::NUM_GROUPS-1:0][hsra_pkg::DATA_W-1:0] guard;
        logic [hsra_pkg::NUM_GROUPS-1:0][hsra_pkg::DATA_W-1:0] flim;
        logic [hsra_pkg::NUM_GROUPS-1:0][hsra_pkg::DATA_W-1:0] pset;
        logic [hsra_pkg::DATA_W-1:0] dwide;
        logic [hsra_pkg::DATA_W-1:0] evq_ptr;
        logic [hsra_pkg::DATA_W-1:0] evq_len;
        logic svc_stb;
        logic [hsra_pkg::GROUP_W-1:0] svc_grp;
        logic [hsra_pkg::DATA_W-1:0] svc_code;
        logic [hsra_pkg::DATA_W-1:0] svc_base;
    } hsra_dev_state_t;

    hsra_dev_state_t s_q;
    hsra_dev_state_t s_d;
    // Channel RAM kept outside the struct: large, no reset needed
    logic [hsra_pkg::DATA_W-1:0] ram_q [hsra_pkg::NUM_GROUPS][hsra_pkg::RAM_WORDS];
    logic ram_we;
    logic [hsra_pkg::RAM_IDX_W-1:0] ram_idx;
    logic [hsra_pkg::DATA_W-1:0] ram_rd;

    // Map a RAM byte offset to a word index; six areas of 128 or 256 bytes
    function automatic logic [hsra_pkg::RAM_IDX_W-1:0] ram_index(
        input logic [hsra_pkg::ADDR_W-1:0] a);
        logic [hsra_pkg::ADDR_W-1:0] rel;
        rel = a - hsra_pkg::OFS_TX_SLOT;
        return rel[hsra_pkg::RAM_IDX_W+1:2];
    endfunction

    function automatic logic is_ram(input logic [hsra_pkg::ADDR_W-1:0] a);
        return (a >= hsra_pkg::OFS_TX_SLOT) && (a < hsra_pkg::OFS_RAM_END);
    endfunction

    assign ram_idx = ram_index(LINK.addr);
    assign ram_rd = ram_q[LINK.grp][ram_idx];

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.svc_stb = 1'b0;
        ram_we = 1'b0;
        case (s_q.st)
            ST_IDLE: begin
                if (LINK.req) begin
                    // Answer data only moves together with the done pulse
                    if (is_ram(LINK.addr)) begin
                        s_d.st = ST_DMA;
                        s_d.cnt = hsra_pkg::DMA_LAT_CNT;
                    end else begin
                        s_d.rdata = hsra_pkg::ALL_ONES;
                        s_d.st = ST_DONE;
                        s_d.done = 1'b1;
                        case (LINK.addr)
                            hsra_pkg::OFS_GROUP_BASE: begin
                                s_d.rdata = s_q.base[LINK.grp];
                                // Low bits forced zero to keep 2 kB alignment
                                if (LINK.wr)
                                    s_d.base[LINK.grp] = LINK.wdata
                                        & hsra_pkg::BASE_ALIGN_MASK;
                            end
                            hsra_pkg::OFS_DUAL_BASE: begin
                                s_d.rdata = s_q.dual[LINK.grp];
                                if (LINK.wr)
                                    s_d.dual[LINK.grp] = LINK.wdata;
                            end
                            hsra_pkg::OFS_SVC_REQ: begin
                                s_d.rdata = s_q.svc[LINK.grp];
                                if (LINK.wr) begin
                                    s_d.svc[LINK.grp] = LINK.wdata;
                                    s_d.svc_stb = 1'b1;
                                    s_d.svc_grp = LINK.grp;
                                    s_d.svc_code = LINK.wdata;
                                    s_d.svc_base = s_q.base[LINK.grp];
                                end
                            end
                            hsra_pkg::OFS_INT_STATUS: begin
                                s_d.rdata = s_q.ists[LINK.grp];
                                if (LINK.wr)
                                    s_d.ists[LINK.grp] = LINK.wdata;
                            end
                            hsra_pkg::OFS_DEVICE_WIDE: begin
                                s_d.rdata = s_q.dwide;
                                if (LINK.wr)
                                    s_d.dwide = LINK.wdata;
                            end
                            hsra_pkg::OFS_EVQ_PTR: begin
                                s_d.rdata = s_q.evq_ptr;
                                if (LINK.wr)
                                    s_d.evq_ptr = LINK.wdata;
                            end
                            hsra_pkg::OFS_EVQ_LEN: begin
                                s_d.rdata = s_q.evq_len;
                                if (LINK.wr)
                                    s_d.evq_len = LINK.wdata;
                            end
                            hsra_pkg::OFS_GROUP_SET: begin
                                s_d.rdata = s_q.gset[LINK.grp];
                                if (LINK.wr)
                                    s_d.gset[LINK.grp] = LINK.wdata;
                            end
                            hsra_pkg::OFS_RANGE_GUARD: begin
                                s_d.rdata = s_q.guard[LINK.grp];
                                if (LINK.wr)
                                    s_d.guard[LINK.grp] = LINK.wdata;
                            end
                            hsra_pkg::OFS_FRAME_LIM: begin
                                s_d.rdata = s_q.flim[LINK.grp];
                                if (LINK.wr)
                                    s_d.flim[LINK.grp] = LINK.wdata;
                            end
                            hsra_pkg::OFS_PORT_SET: begin
                                s_d.rdata = s_q.pset[LINK.grp];
                                if (LINK.wr)
                                    s_d.pset[LINK.grp] = LINK.wdata;
                            end
                            default: begin
                                s_d.rdata = hsra_pkg::ALL_ONES;
                            end
                        endcase
                    end
                end
            end
            ST_DMA: begin
                // Data phase held until the DMA path finishes
                if (s_q.cnt != 2'h0) begin
                    s_d.cnt = s_q.cnt - 2'h1;
                end else begin
                    s_d.st = ST_DONE;
                    s_d.done = 1'b1;
                    if (I_LINE_CLK_OK[LINK.grp]) begin
                        s_d.rdata = LINK.wr ? hsra_pkg::ZERO_WORD : ram_rd;
                        ram_we = LINK.wr;
                    end else begin
                        s_d.rdata = hsra_pkg::DEAD_ACCESS_WORD;
                    end
                end
            end
            ST_DONE: begin
                // Wait for the host to drop the request
                if (!LINK.req)
                    s_d.st = ST_IDLE;
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (ram_we)
            ram_q[LINK.grp][ram_idx] <= LINK.wdata;
    end

    assign LINK.done = s_q.done;
    assign LINK.rdata = s_q.rdata;
    assign O_SVC_STROBE = s_q.svc_stb;
    assign O_SVC_GROUP = s_q.svc_grp;
    assign O_SVC_CODE = s_q.svc_code;
    assign O_SVC_BASE = s_q.svc_base;
endmodule // hsra_dev

// file: rtl/hsra_host.sv
// Host bridge end: turns user commands into slave accesses on the link
`timescale 1ns/100ps
module hsra_host (
    input wire logic I_CLOCK, // System clock
    input wire logic I_SRST, // Synchronous reset
    hsra_if.host LINK, // Slave access link
    input wire logic I_CMD_VALID, // Command present
    input wire logic I_CMD_WR, // 1 write, 0 read
    input wire logic [hsra_pkg::GROUP_W-1:0] I_CMD_GRP, // Target group
    input wire logic [hsra_pkg::ADDR_W-1:0] I_CMD_ADDR, // Byte offset
    input wire logic [hsra_pkg::DATA_W-1:0] I_CMD_WDATA, // Write data
    input wire logic I_CHAN_ACTIVE, // Any channel active
    output logic O_CMD_READY, // Ready for a command
    output logic O_RSP_VALID, // Access finished, one cycle
    output logic [hsra_pkg::DATA_W-1:0] O_RSP_RDATA, // Read data
    output logic O_CMD_BLOCKED // Command refused, one cycle
);
    typedef enum logic [1:0] {HS_IDLE, HS_WAIT, HS_GAP} hsra_hst_t;
    typedef struct packed {
        hsra_hst_t st;
        logic [1:0] gap;
        logic req;
        logic wr;
        logic [hsra_pkg::GROUP_W-1:0] grp;
        logic [hsra_pkg::ADDR_W-1:0] addr;
        logic [hsra_pkg::DATA_W-1:0] wdata;
        logic rsp;
        logic [hsra_pkg::DATA_W-1:0] rdata;
        logic blk;
        logic rdy;
    } hsra_host_state_t;

    hsra_host_state_t s_q;
    hsra_host_state_t s_d;

    // Only these targets are safe once any channel runs
    function automatic logic allowed(input logic [hsra_pkg::ADDR_W-1:0] a);
        return (a == hsra_pkg::OFS_GROUP_BASE) || (a == hsra_pkg::OFS_SVC_REQ) ||
            (a == hsra_pkg::OFS_INT_STATUS);
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.rsp = 1'b0;
        s_d.blk = 1'b0;
        case (s_q.st)
            HS_IDLE: begin
                if (I_CMD_VALID) begin
                    if (I_CHAN_ACTIVE && !allowed(I_CMD_ADDR)) begin
                        s_d.blk = 1'b1;
                    end else begin
                        s_d.st = HS_WAIT;
                        s_d.req = 1'b1;
                        s_d.wr = I_CMD_WR;
                        s_d.grp = I_CMD_GRP;
                        s_d.addr = I_CMD_ADDR;
                        s_d.wdata = (I_CMD_WR && I_CMD_ADDR == hsra_pkg::OFS_GROUP_BASE)
                            ? (I_CMD_WDATA & hsra_pkg::BASE_ALIGN_MASK)
                            : I_CMD_WDATA;
                    end
                end
            end
            HS_WAIT: begin
                if (LINK.done) begin
                    s_d.req = 1'b0;
                    s_d.rsp = 1'b1;
                    s_d.rdata = LINK.rdata;
                    s_d.st = HS_GAP;
                    s_d.gap = hsra_pkg::SETTLE_CNT;
                end
            end
            HS_GAP: begin
                if (s_q.gap != 2'h0)
                    s_d.gap = s_q.gap - 2'h1;
                else
                    s_d.st = HS_IDLE;
            end
            default: begin
                s_d.st = HS_IDLE;
            end
        endcase
        // Ready registered so the output comes straight from a flop
        s_d.rdy = (s_d.st == HS_IDLE);
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            s_q <= '0;
            s_q.st <= HS_IDLE;
            s_q.rdy <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign LINK.req = s_q.req;
    assign LINK.wr = s_q.wr;
    assign LINK.grp = s_q.grp;
    assign LINK.addr = s_q.addr;
    assign LINK.wdata = s_q.wdata;
    assign O_CMD_READY = s_q.rdy;
    assign O_RSP_VALID = s_q.rsp;
    assign O_RSP_RDATA = s_q.rdata;
    assign O_CMD_BLOCKED = s_q.blk;
endmodule // hsra_host

// file: testbench/hsra_link_sva.sv
// Concurrent checks on the slave access link between host end and device end
`timescale 1ns/100ps
module hsra_link_sva (
    input wire logic I_CLOCK, // System clock
    input wire logic I_SRST, // Synchronous reset
    input wire logic req, // Access request
    input wire logic wr, // Write select
    input wire logic [hsra_pkg::GROUP_W-1:0] grp, // Target group
    input wire logic [hsra_pkg::ADDR_W-1:0] addr, // Byte offset
    input wire logic [hsra_pkg::DATA_W-1:0] wdata, // Write data
    input wire logic done, // Answer pulse
    input wire logic [hsra_pkg::DATA_W-1:0] rdata, // Answer data
    input wire logic [hsra_pkg::NUM_GROUPS-1:0] I_LINE_CLK_OK // Line clocks live
);
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (I_SRST);
    logic in_ram;
    logic bad;
    logic live;
    assign in_ram = (addr >= hsra_pkg::OFS_TX_SLOT) && (addr < hsra_pkg::OFS_RAM_END);
    assign bad = (addr > hsra_pkg::OFS_PORT_SET) ||
                 ((addr > hsra_pkg::OFS_INT_STATUS) && (addr < hsra_pkg::OFS_TX_SLOT));
    assign live = I_LINE_CLK_OK[grp];
    a_reg_answer_time: assert property ($rose(req) && !in_ram |-> ##[1:2] done)
        else $error("register access answer late");
    a_ram_held_pending: assert property ($rose(req) && in_ram |-> !done [*3] ##[1:3] done)
        else $error("channel RAM answer outside DMA window");
    a_done_within_req: assert property (done |-> req)
        else $error("answer without a request");
    a_done_single_pulse: assert property (done |=> !done)
        else $error("answer pulse longer than one cycle");
    a_dead_clock_word: assert property (done && in_ram && !live |-> rdata == hsra_pkg::DEAD_ACCESS_WORD)
        else $error("dead clock access did not give marker word");
    a_live_ram_write: assert property (done && wr && in_ram && live |-> rdata == hsra_pkg::ZERO_WORD)
        else $error("live RAM write answer not zero");
    a_bad_read_ones: assert property (done && !wr && bad |-> rdata == hsra_pkg::ALL_ONES)
        else $error("invalid address read not all ones");
    a_rdata_hold: assert property (!done |-> $stable(rdata))
        else $error("answer data changed without an answer");
    c_dead_access: cover property (done && in_ram && !live);
    c_bad_read: cover property (done && !wr && bad);
    c_live_ram_write: cover property (done && wr && in_ram && live && wdata != rdata);
endmodule // hsra_link_sva

// file: testbench/tb_top.sv
// Self-checking bench joining host end and device end through the link
`timescale 1ns/100ps
module tb_top;
    logic clk, srst, v, cwr, act, ready, rsp, blkp, blk, strobe;
    logic [1:0] cgrp, sgrp, s_grp;
    logic [11:0] caddr;
    logic [31:0] cwd, rrd, last, scode, sbase, s_code, s_base;
    logic [3:0] lck;
    int n_fail, compares, n_svc, i, g;
    logic [11:0] reg_ofs [8] = '{12'h004, 12'h00C, 12'h604, 12'h608,
                                 12'h60C, 12'h610, 12'h614, 12'h618};
    logic [11:0] ram_ofs [8] = '{12'h200, 12'h27C, 12'h280, 12'h380,
                                 12'h400, 12'h480, 12'h580, 12'h5FC};
    hsra_if link_if();
    hsra_host u_hsra_host (.I_CLOCK(clk), .I_SRST(srst), .LINK(link_if), .I_CMD_VALID(v),
        .I_CMD_WR(cwr), .I_CMD_GRP(cgrp), .I_CMD_ADDR(caddr), .I_CMD_WDATA(cwd),
        .I_CHAN_ACTIVE(act), .O_CMD_READY(ready), .O_RSP_VALID(rsp), .O_RSP_RDATA(rrd),
        .O_CMD_BLOCKED(blkp));
    hsra_dev u_hsra_dev (.I_CLOCK(clk), .I_SRST(srst), .LINK(link_if), .I_LINE_CLK_OK(lck),
        .I_CHAN_ACTIVE(act), .O_SVC_STROBE(strobe), .O_SVC_GROUP(sgrp), .O_SVC_CODE(scode),
        .O_SVC_BASE(sbase));
    hsra_link_sva u_hsra_link_sva (.I_CLOCK(clk), .I_SRST(srst), .req(link_if.req),
        .wr(link_if.wr), .grp(link_if.grp), .addr(link_if.addr), .wdata(link_if.wdata),
        .done(link_if.done), .rdata(link_if.rdata), .I_LINE_CLK_OK(lck));
    always #5 clk = ~clk;
    // Strobe and its fields sampled mid-cycle, clear of the launching edge
    always @(negedge clk) begin
        if (strobe === 1'b1) begin
            n_svc++;
            s_code = scode;
            s_grp = sgrp;
            s_base = sbase;
        end
    end
    function automatic logic [31:0] pat(input logic [1:0] g, input logic [11:0] a);
        return {4'hA, 2'h0, g, 12'h000, a};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [1:0] gr, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk);
        #1;
        // Ready seen off-edge, so the next edge surely takes the command
        while (ready !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        v = 1'b1;
        cwr = w;
        cgrp = gr;
        caddr = a;
        cwd = d;
        @(posedge clk);
        #1 v = 1'b0;
        for (k = 0; k < 40; k++) begin
            if (rsp === 1'b1 || blkp === 1'b1) break;
            @(posedge clk);
            #1;
        end
        if (k == 40) chk(32'hFFFFFFFF, 32'h00000000);
        blk = blkp;
        last = rrd;
    endtask
    task automatic rd(input logic [1:0] gr, input logic [11:0] a, input logic [31:0] exp);
        acc(1'b0, gr, a, 32'h00000000);
        chk(last, exp);
    endtask
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Whole run needs about seven hundred cycles
    initial begin
        #100000;
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test;
    end
    initial begin
        clk = 1'b0; srst = 1'b1; v = 1'b0; cwr = 1'b0; cgrp = 2'h0; caddr = 12'h000;
        cwd = 32'h00000000; act = 1'b0; lck = 4'hF; n_fail = 0; compares = 0; n_svc = 0;
        repeat (12) @(posedge clk);
        #1 srst = 1'b0;
        acc(1'b1, 2'h1, hsra_pkg::OFS_GROUP_BASE, 32'hABCDE7FF);
        rd(2'h1, hsra_pkg::OFS_GROUP_BASE, 32'hABCDE7FF & hsra_pkg::BASE_ALIGN_MASK);
        for (i = 0; i < 8; i++) acc(1'b1, 2'h0, reg_ofs[i], 32'h5A000000 | 32'(i));
        for (i = 0; i < 8; i++) rd(2'h0, reg_ofs[i], 32'h5A000000 | 32'(i));
        $display("test registers done");
        for (g = 0; g < 4; g++) begin
            for (i = 0; i < 8; i++) begin
                acc(1'b1, 2'(g), ram_ofs[i], pat(2'(g), ram_ofs[i]));
                chk(last, hsra_pkg::ZERO_WORD);
            end
        end
        for (g = 0; g < 4; g++) begin
            for (i = 0; i < 8; i++) rd(2'(g), ram_ofs[i], pat(2'(g), ram_ofs[i]));
        end
        $display("test channel ram done");
        lck = 4'hB;
        rd(2'h2, 12'h400, hsra_pkg::DEAD_ACCESS_WORD);
        acc(1'b1, 2'h2, 12'h400, 32'h11111111);
        chk(last, hsra_pkg::DEAD_ACCESS_WORD);
        rd(2'h3, 12'h400, pat(2'h3, 12'h400));
        lck = 4'hF;
        rd(2'h2, 12'h400, pat(2'h2, 12'h400));
        $display("test dead clocks done");
        rd(2'h0, 12'h010, hsra_pkg::ALL_ONES);
        acc(1'b1, 2'h0, 12'h7FC, 32'h00000000);
        rd(2'h0, 12'h7FC, hsra_pkg::ALL_ONES);
        $display("test invalid addresses done");
        acc(1'b1, 2'h3, hsra_pkg::OFS_GROUP_BASE, 32'h00040800);
        acc(1'b1, 2'h3, hsra_pkg::OFS_SVC_REQ, 32'h00000A03);
        chk(32'(n_svc), 32'h00000001);
        chk({s_grp, s_code[29:0]}, {2'h3, 30'h00000A03});
        chk(s_base, 32'h00040800);
        rd(2'h3, hsra_pkg::OFS_SVC_REQ, 32'h00000A03);
        acc(1'b1, 2'h3, hsra_pkg::OFS_GROUP_BASE, 32'h00081000);
        acc(1'b1, 2'h3, hsra_pkg::OFS_SVC_REQ, 32'h00000B03);
        chk(s_base, 32'h00081000);
        $display("test service request done");
        act = 1'b1;
        acc(1'b0, 2'h0, hsra_pkg::OFS_TX_SLOT, 32'h00000000);
        chk({31'h0, blk}, 32'h00000001);
        acc(1'b1, 2'h2, hsra_pkg::OFS_DEVICE_WIDE, 32'h00000000);
        chk({31'h0, blk}, 32'h00000001);
        acc(1'b1, 2'h0, hsra_pkg::OFS_SVC_REQ, 32'h00000C00);
        chk({31'h0, blk}, 32'h00000000);
        chk(32'(n_svc), 32'h00000003);
        rd(2'h0, hsra_pkg::OFS_INT_STATUS, 32'h5A000001);
        act = 1'b0;
        rd(2'h0, hsra_pkg::OFS_TX_SLOT, pat(2'h0, 12'h200));
        $display("test active channels done");
        end_of_test;
    end
endmodule // tb_top
